// ### pkg/sweep_seq_pkg.sv
// constants for the impedance sweep sequencer
package sweep_seq_pkg;
   // ***********************************************
   // register byte addresses
   // ***********************************************
   localparam logic [7:0] ADDR_CTRL_HI = 8'h80;
   localparam logic [7:0] ADDR_CTRL_LO = 8'h81;
   localparam logic [7:0] ADDR_START_FREQ = 8'h82;
   localparam logic [7:0] ADDR_STEP_FREQ = 8'h85;
   localparam logic [7:0] ADDR_STEP_COUNT = 8'h88;
   localparam logic [7:0] ADDR_SETTLE = 8'h8A;
   localparam logic [7:0] ADDR_STATUS = 8'h8F;
   localparam logic [7:0] ADDR_REAL = 8'h94;
   localparam logic [7:0] ADDR_IMAG = 8'h96;
   // ***********************************************
   // reset values and fields
   // ***********************************************
   localparam logic [15:0] CTRL_RESET = 16'hA000;
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 12;
   localparam int RANGE_MSB = 10;
   localparam int RANGE_LSB = 9;
   localparam int GAIN_BIT = 8;
   localparam int RESET_BIT = 4;
   localparam int STAT_VALID_BIT = 1;
   localparam int STAT_DONE_BIT = 2;
   localparam int COUNT_W = 9;
   localparam int SETTLE_MULT_MSB = 10;
   localparam int SETTLE_MULT_LSB = 9;
   localparam logic [1:0] MULT_X2 = 2'h1;
   localparam logic [1:0] MULT_X4 = 2'h3;
   localparam logic [10:0] SAMPLES_PER_POINT = 11'h400;
   // ***********************************************
   // command codes
   // ***********************************************
   localparam logic [3:0] CMD_INIT = 4'h1;
   localparam logic [3:0] CMD_START = 4'h2;
   localparam logic [3:0] CMD_INCR = 4'h3;
   localparam logic [3:0] CMD_REPEAT = 4'h4;
   localparam logic [3:0] CMD_POWER_DOWN = 4'hA;
   localparam logic [3:0] CMD_STANDBY = 4'hB;
   // sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_EXCITE = 5'h02,
      ST_SETTLE = 5'h04,
      ST_MEASURE = 5'h08,
      ST_WAIT = 5'h10
   } seq_state_e;
endpackage : sweep_seq_pkg

// ### design/impedance_sweep_sequencer.sv
// register file, command decode and sweep sequencer
`timescale 1ns/1ns
module impedance_sweep_sequencer (
   input wire logic i_clk, // system clock, 50 MHz
   input wire logic i_arst_n, // async reset, active low
   input wire logic i_wr, // byte write strobe
   input wire logic [7:0] i_addr, // register byte address
   input wire logic [7:0] i_wdata, // write data byte
   input wire logic [7:0] i_raddr, // read byte address
   output logic [7:0] o_rdata, // read data byte
   input wire logic i_excite_cycle, // one pulse per excitation cycle
   input wire logic i_sample, // one pulse per converter sample
   input wire logic [15:0] i_real, // dft real result
   input wire logic [15:0] i_imag, // dft imaginary result
   output logic [23:0] o_tone_synthesizer_freq, // current frequency code
   output logic o_tone_synthesizer_en, // synthesizer running
   output logic o_pins_grounded, // excitation and response pins tied low
   output logic o_powered, // analog path powered
   output logic [1:0] o_output_range, // excitation amplitude select
   output logic o_response_gain_x1, // 1 = x1, 0 = x5
   output logic o_measuring // converter sampling window
);
   // ***********************************************
   // storage
   // ***********************************************
   logic [15:0] ctrl_q;
   logic [7:0] start_q [3];
   logic [7:0] step_q [3];
   logic [7:0] count_q [2];
   logic [7:0] settle_q [2];
   logic [15:0] real_q; // captured real result
   logic [15:0] real_d;
   logic [15:0] imag_q; // captured imaginary result
   logic [15:0] imag_d;
   logic valid_q; // valid-result flag
   logic done_q; // sweep-complete flag
   logic pdown_q; // power-down mode
   sweep_seq_pkg::seq_state_e state_q; // sequencer state
   sweep_seq_pkg::seq_state_e state_d;
   logic [23:0] freq_q; // frequency code in use
   logic [23:0] freq_d;
   logic [10:0] settle_cnt_q; // excitation cycles seen while settling
   logic [10:0] settle_cnt_d;
   logic [10:0] samp_cnt_q; // converter samples taken at this point
   logic [10:0] samp_cnt_d;
   logic [8:0] point_q; // increments done since start
   logic [8:0] point_d;
   // per-byte write strobes of the sweep setup registers
   logic [2:0] wr_start_b;
   logic [2:0] wr_step_b;
   logic [1:0] wr_count_b;
   logic [1:0] wr_settle_b;

   // ***********************************************
   // decode
   // ***********************************************
   wire logic wr_ctrl_hi = i_wr && i_addr == sweep_seq_pkg::ADDR_CTRL_HI;
   wire logic wr_ctrl_lo = i_wr && i_addr == sweep_seq_pkg::ADDR_CTRL_LO;
   wire logic [3:0] cmd = i_wdata[7:4];
   wire logic cmd_init = wr_ctrl_hi && cmd == sweep_seq_pkg::CMD_INIT;
   wire logic cmd_start = wr_ctrl_hi && cmd == sweep_seq_pkg::CMD_START;
   wire logic cmd_incr = wr_ctrl_hi && cmd == sweep_seq_pkg::CMD_INCR;
   wire logic cmd_rep = wr_ctrl_hi && cmd == sweep_seq_pkg::CMD_REPEAT;
   wire logic cmd_pd = wr_ctrl_hi && cmd == sweep_seq_pkg::CMD_POWER_DOWN;
   wire logic cmd_sb = wr_ctrl_hi && cmd == sweep_seq_pkg::CMD_STANDBY;
   wire logic cmd_rst = wr_ctrl_lo && i_wdata[sweep_seq_pkg::RESET_BIT];
   wire logic [23:0] start_freq = {start_q[0], start_q[1], start_q[2]};
   wire logic [23:0] step_freq = {step_q[0], step_q[1], step_q[2]};
   wire logic [8:0] step_total = {count_q[0][0], count_q[1]};
   wire logic [8:0] settle_base = {settle_q[0][0], settle_q[1]};
   wire logic [1:0] settle_mult = settle_q[0][2:1];
   // settling multiplier, reserved code taken as x1
   wire logic [10:0] settle_target =
      settle_mult == sweep_seq_pkg::MULT_X4 ? {settle_base, 2'h0} :
      settle_mult == sweep_seq_pkg::MULT_X2 ? {1'h0, settle_base, 1'h0} :
      {2'h0, settle_base};
   wire logic meas_end = state_q == sweep_seq_pkg::ST_MEASURE && i_sample &&
      samp_cnt_q == sweep_seq_pkg::SAMPLES_PER_POINT - 11'h1;
   wire logic last_point = point_q == step_total;

   // ***********************************************
   // register writes
   // ***********************************************
   // control word; reset value puts the part in power-down
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_q <= sweep_seq_pkg::CTRL_RESET;
      end else if (wr_ctrl_hi) begin
         ctrl_q[15:8] <= i_wdata;
      end else if (wr_ctrl_lo) begin
         ctrl_q[7:0] <= i_wdata;
      end
   end

   genvar gi;
   generate
      // frequency bytes, no reset so contents survive it
      for (gi = 0; gi < 3; gi++) begin : g_freq
         assign wr_start_b[gi] = i_wr && i_addr == sweep_seq_pkg::ADDR_START_FREQ + 8'(gi);
         assign wr_step_b[gi] = i_wr && i_addr == sweep_seq_pkg::ADDR_STEP_FREQ + 8'(gi);
         always_ff @(posedge i_clk) begin
            if (wr_start_b[gi]) begin
               start_q[gi] <= i_wdata;
            end
            if (wr_step_b[gi]) begin
               step_q[gi] <= i_wdata;
            end
         end
      end
      // step count and settle bytes, each byte has exactly one writer
      for (gi = 0; gi < 2; gi++) begin : g_word
         assign wr_count_b[gi] = i_wr && i_addr == sweep_seq_pkg::ADDR_STEP_COUNT + 8'(gi);
         assign wr_settle_b[gi] = i_wr && i_addr == sweep_seq_pkg::ADDR_SETTLE + 8'(gi);
         always_ff @(posedge i_clk) begin
            if (wr_count_b[gi]) begin
               count_q[gi] <= i_wdata;
            end
            if (wr_settle_b[gi]) begin
               settle_q[gi] <= i_wdata;
            end
         end
      end
   endgenerate

   // results, not reset, loaded at end of each point
   always_ff @(posedge i_clk) begin
      real_q <= real_d;
      imag_q <= imag_d;
   end
   assign real_d = meas_end ? i_real : real_q;
   assign imag_d = meas_end ? i_imag : imag_q;

   // ***********************************************
   // status flags, set wins over clear
   // ***********************************************
   // valid-result flag, end of measurement beats a clearing command
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         valid_q <= 1'b0;
      end else if (meas_end) begin
         valid_q <= 1'b1;
      end else if (cmd_start || cmd_incr || cmd_rep || cmd_rst) begin
         valid_q <= 1'b0;
      end
   end

   // sweep-complete flag, end of last point beats start or reset
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         done_q <= 1'b0;
      end else if (meas_end && last_point) begin
         done_q <= 1'b1;
      end else if (cmd_start || cmd_rst) begin
         done_q <= 1'b0;
      end
   end

   // power state, power-down wins over standby and initialize
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pdown_q <= 1'b1;
      end else if (cmd_pd) begin
         pdown_q <= 1'b1;
      end else if (cmd_sb || cmd_init) begin
         pdown_q <= 1'b0;
      end
   end

   // ***********************************************
   // sequencer
   // ***********************************************
   always_comb begin
      state_d = state_q;
      freq_d = freq_q;
      settle_cnt_d = settle_cnt_q;
      samp_cnt_d = samp_cnt_q;
      point_d = point_q;
      if (cmd_rst || cmd_pd || cmd_sb) begin
         state_d = sweep_seq_pkg::ST_IDLE;
      end else if (cmd_init) begin
         state_d = sweep_seq_pkg::ST_EXCITE;
         freq_d = start_freq;
      end else if (cmd_start && state_q != sweep_seq_pkg::ST_IDLE) begin
         state_d = sweep_seq_pkg::ST_SETTLE;
         freq_d = start_freq;
         point_d = 9'h0;
         settle_cnt_d = 11'h0;
      end else if (cmd_incr && state_q == sweep_seq_pkg::ST_WAIT) begin
         state_d = sweep_seq_pkg::ST_SETTLE;
         freq_d = freq_q + step_freq;
         point_d = point_q + 9'h1;
         settle_cnt_d = 11'h0;
      end else if (cmd_rep && state_q == sweep_seq_pkg::ST_WAIT) begin
         state_d = sweep_seq_pkg::ST_SETTLE;
         settle_cnt_d = 11'h0;
      end else begin
         case (state_q)
            sweep_seq_pkg::ST_SETTLE: begin
               if (settle_cnt_q >= settle_target) begin
                  state_d = sweep_seq_pkg::ST_MEASURE;
                  samp_cnt_d = 11'h0;
               end else if (i_excite_cycle) begin
                  settle_cnt_d = settle_cnt_q + 11'h1;
               end
            end
            sweep_seq_pkg::ST_MEASURE: begin
               if (meas_end) begin
                  state_d = sweep_seq_pkg::ST_WAIT;
               end else if (i_sample) begin
                  samp_cnt_d = samp_cnt_q + 11'h1;
               end
            end
            sweep_seq_pkg::ST_IDLE, sweep_seq_pkg::ST_EXCITE,
            sweep_seq_pkg::ST_WAIT: begin
               state_d = state_q;
            end
            default: begin
               state_d = sweep_seq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= sweep_seq_pkg::ST_IDLE;
         freq_q <= 24'h0;
         settle_cnt_q <= 11'h0;
         samp_cnt_q <= 11'h0;
         point_q <= 9'h0;
      end else begin
         state_q <= state_d;
         freq_q <= freq_d;
         settle_cnt_q <= settle_cnt_d;
         samp_cnt_q <= samp_cnt_d;
         point_q <= point_d;
      end
   end

   // ***********************************************
   // outputs and read mux
   // ***********************************************
   assign o_tone_synthesizer_freq = freq_q;
   assign o_tone_synthesizer_en = state_q != sweep_seq_pkg::ST_IDLE && !pdown_q;
   assign o_powered = !pdown_q;
   assign o_pins_grounded = pdown_q || state_q == sweep_seq_pkg::ST_IDLE;
   assign o_output_range = ctrl_q[sweep_seq_pkg::RANGE_MSB:sweep_seq_pkg::RANGE_LSB];
   assign o_response_gain_x1 = ctrl_q[sweep_seq_pkg::GAIN_BIT];
   assign o_measuring = state_q == sweep_seq_pkg::ST_MEASURE;

   // byte read select, unmapped reads as zero
   always_comb begin
      case (i_raddr)
         sweep_seq_pkg::ADDR_CTRL_HI: o_rdata = ctrl_q[15:8];
         sweep_seq_pkg::ADDR_CTRL_LO: o_rdata = ctrl_q[7:0];
         sweep_seq_pkg::ADDR_START_FREQ: o_rdata = start_q[0];
         sweep_seq_pkg::ADDR_START_FREQ + 8'h1: o_rdata = start_q[1];
         sweep_seq_pkg::ADDR_START_FREQ + 8'h2: o_rdata = start_q[2];
         sweep_seq_pkg::ADDR_STEP_FREQ: o_rdata = step_q[0];
         sweep_seq_pkg::ADDR_STEP_FREQ + 8'h1: o_rdata = step_q[1];
         sweep_seq_pkg::ADDR_STEP_FREQ + 8'h2: o_rdata = step_q[2];
         sweep_seq_pkg::ADDR_STEP_COUNT: o_rdata = count_q[0];
         sweep_seq_pkg::ADDR_STEP_COUNT + 8'h1: o_rdata = count_q[1];
         sweep_seq_pkg::ADDR_SETTLE: o_rdata = settle_q[0];
         sweep_seq_pkg::ADDR_SETTLE + 8'h1: o_rdata = settle_q[1];
         // status: only valid and complete carry meaning
         sweep_seq_pkg::ADDR_STATUS: o_rdata = {5'h0, done_q, valid_q, 1'h0};
         // results: two's complement, high byte first
         sweep_seq_pkg::ADDR_REAL: o_rdata = real_q[15:8];
         sweep_seq_pkg::ADDR_REAL + 8'h1: o_rdata = real_q[7:0];
         sweep_seq_pkg::ADDR_IMAG: o_rdata = imag_q[15:8];
         sweep_seq_pkg::ADDR_IMAG + 8'h1: o_rdata = imag_q[7:0];
         default: o_rdata = 8'h00;
      endcase
   end
endmodule : impedance_sweep_sequencer

// ### testbench/sweep_seq_assertions.sv
// port checker for the impedance sweep sequencer
`timescale 1ns/1ns
module sweep_seq_checker (
   input wire logic i_clk, // system clock
   input wire logic i_arst_n, // async reset, active low
   input wire logic i_wr, // byte write strobe
   input wire logic [7:0] i_addr, // write address
   input wire logic [7:0] i_wdata, // write byte
   input wire logic [7:0] i_raddr, // read address
   input wire logic [7:0] o_rdata, // read byte
   input wire logic i_excite_cycle, // excitation pulse
   input wire logic o_tone_synthesizer_en, // synthesizer running
   input wire logic o_pins_grounded, // pins tied low
   input wire logic o_powered, // analog path powered
   input wire logic [1:0] o_output_range, // amplitude select
   input wire logic o_response_gain_x1, // gain select
   input wire logic o_measuring // sampling window
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   // ***********************************************
   // command decode helpers
   // ***********************************************
   wire ctl_wr = i_wr && i_addr == 8'h80;
   wire [3:0] cmd = i_wdata[7:4];
   reset_defaults_a: assert property ($rose(i_arst_n) |-> !o_powered && o_pins_grounded
      && o_output_range == 2'h0 && !o_response_gain_x1) else $error("bad power-up state");
   standby_ground_a: assert property (ctl_wr && cmd == 4'hB |=> o_powered && o_pins_grounded)
      else $error("standby state wrong");
   init_runs_a: assert property (ctl_wr && cmd == 4'h1 |=> o_tone_synthesizer_en && !o_measuring)
      else $error("initialize did not run tone");
   range_gain_a: assert property (ctl_wr |=> o_output_range == $past(i_wdata[2:1])
      && o_response_gain_x1 == $past(i_wdata[0])) else $error("range or gain wrong");
   settle_first_a: assert property ($rose(o_measuring) |-> $past(i_excite_cycle, 2))
      else $error("measuring began without settling");
   reset_abort_a: assert property (i_wr && i_addr == 8'h81 && i_wdata[4]
      |=> !o_measuring && o_pins_grounded) else $error("reset did not abort");
   valid_clear_a: assert property (ctl_wr && cmd inside {4'h2, 4'h3, 4'h4} && !o_measuring
      && !o_pins_grounded |=> i_raddr != 8'h8F || !o_rdata[1]) else $error("valid not cleared");
   nop_hold_a: assert property (ctl_wr && cmd == 4'h0 && !o_measuring
      |=> $stable(o_powered) && $stable(o_tone_synthesizer_en)) else $error("nop changed state");
   power_down_a: assert property (ctl_wr && cmd == 4'hA |=> !o_powered ##0 o_pins_grounded)
      else $error("power-down wrong");
endmodule : sweep_seq_checker
bind impedance_sweep_sequencer sweep_seq_checker u_sweep_seq_checker (.i_clk, .i_arst_n,
   .i_wr, .i_addr, .i_wdata, .i_raddr, .o_rdata, .i_excite_cycle, .o_tone_synthesizer_en,
   .o_pins_grounded, .o_powered, .o_output_range, .o_response_gain_x1, .o_measuring);

// ### testbench/analog_front_model.sv
// analog front end model: excitation and sample pulses, dft results
`timescale 1ns/1ns
module analog_front_model #(
   parameter logic [15:0] REAL_VAL = 16'h1234,
   parameter logic [15:0] IMAG_VAL = 16'hFEDC
) (
   input wire logic i_clk, // system clock
   input wire logic i_en, // synthesizer running
   input wire logic i_meas, // sampling window
   output logic o_excite, // excitation cycle pulse
   output logic o_sample, // sample pulse
   output logic [15:0] o_real, // real result
   output logic [15:0] o_imag // imaginary result
);
   logic [1:0] cnt_q = 2'h0;
   initial begin
      o_excite = 1'b0;
      o_sample = 1'b0;
   end
   // one excitation pulse per four clocks, one sample per clock
   always @(posedge i_clk) begin
      cnt_q <= i_en ? cnt_q + 2'h1 : 2'h0;
      o_excite <= i_en && cnt_q == 2'h3;
      o_sample <= i_meas;
   end
   // results only hold while sampling, inverted otherwise
   assign o_real = i_meas ? REAL_VAL : ~REAL_VAL;
   assign o_imag = i_meas ? IMAG_VAL : ~IMAG_VAL;
endmodule : analog_front_model

// ### testbench/test_impedance_sweep_sequencer.sv
// self-checking bench for the impedance sweep sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module test_impedance_sweep_sequencer;
   logic i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_raddr = 8'h8F, o_rdata;
   logic i_excite_cycle, i_sample, o_tone_synthesizer_en, o_pins_grounded, o_powered;
   logic o_response_gain_x1, o_measuring;
   logic [15:0] i_real, i_imag;
   logic [23:0] o_tone_synthesizer_freq;
   logic [1:0] o_output_range;
   logic [7:0] cfg [10] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 8'h10, 8'hFE, 8'h01, 8'h02, 8'h03};
   logic [7:0] mult [4] = '{8'h02, 8'h06, 8'h04, 8'h00};
   int exp_settle [4] = '{6, 12, 3, 3};
   int bad_count = 0, compares = 0;
   logic pw;
   impedance_sweep_sequencer u_impedance_sweep_sequencer (.i_clk, .i_arst_n, .i_wr, .i_addr,
      .i_wdata, .i_raddr, .o_rdata, .i_excite_cycle, .i_sample, .i_real, .i_imag,
      .o_tone_synthesizer_freq, .o_tone_synthesizer_en, .o_pins_grounded, .o_powered,
      .o_output_range, .o_response_gain_x1, .o_measuring);
   analog_front_model u_analog_front_model (.i_clk, .i_en(o_tone_synthesizer_en),
      .i_meas(o_measuring), .o_excite(i_excite_cycle), .o_sample(i_sample), .o_real(i_real),
      .o_imag(i_imag));
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   // ***********************************************
   // access tasks
   // ***********************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1 i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(posedge i_clk);
      #1 i_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      i_raddr = a;
      #1 `CHK(o_rdata & m, e)
      i_raddr = 8'h8F;
   endtask : rd
   // count excitation pulses until the sampling window opens
   task automatic settle(input int e);
      int n, k;
      n = 0;
      k = 0;
      while (o_measuring !== 1'b1 && k < 500) begin
         if (i_excite_cycle === 1'b1) n++;
         @(posedge i_clk);
         #1 k++;
      end
      `CHK(n, e)
   endtask : settle
   task automatic wait_valid;
      int n;
      n = 0;
      while (o_rdata[1] !== 1'b1 && n < 3000) begin
         @(posedge i_clk);
         #1 n++;
      end
      `CHK(n < 3000, 1'b1)
   endtask : wait_valid
   task automatic conclude;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   // ***********************************************
   // test sequence
   // ***********************************************
   initial begin
      repeat (8) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      rd(8'h80, 8'hA0);
      rd(8'h81, 8'h00);
      rd(8'h8F, 8'h00, 8'h06);
      `CHK({o_powered, o_pins_grounded}, 2'b01)
      for (int i = 0; i < 10; i++) wr(8'h82 + 8'(i), cfg[i]);
      wr(8'h80, 8'hB0);
      `CHK({o_powered, o_pins_grounded}, 2'b11)
      for (int r = 0; r < 4; r++) begin
         wr(8'h80, 8'hB0 | 8'(r << 1 | r & 1));
         `CHK({o_output_range, o_response_gain_x1}, 3'(r << 1 | r & 1))
      end
      wr(8'h80, 8'h17);
      repeat (40) @(posedge i_clk);
      #1 `CHK({o_tone_synthesizer_en, o_measuring, o_tone_synthesizer_freq}, 26'h2010203)
      wr(8'h80, 8'h27);
      settle(6);
      wait_valid();
      rd(8'h8F, 8'h02, 8'h06);
      for (int i = 0; i < 4; i++) rd(8'h94 + 8'(i), i[1] ? i_imag_b(i) : i_real_b(i));
      for (int i = 0; i < 4; i++) begin
         cfg[8] = mult[i];
         wr(8'h8A, mult[i]);
         wr(8'h80, 8'h47);
         rd(8'h8F, 8'h00, 8'h02);
         settle(exp_settle[i]);
         `CHK(o_tone_synthesizer_freq, 24'h010203)
         wait_valid();
      end
      wr(8'h80, 8'h37);
      `CHK(o_tone_synthesizer_freq, 24'h010213)
      settle(3);
      wait_valid();
      rd(8'h8F, 8'h06, 8'h06);
      wr(8'h80, 8'h27);
      rd(8'h8F, 8'h00, 8'h06);
      wr(8'h81, 8'h10);
      rd(8'h8F, 8'h00, 8'h06);
      wr(8'h80, 8'h37);
      repeat (60) @(posedge i_clk);
      #1 `CHK({o_measuring, o_tone_synthesizer_en}, 2'b00)
      for (int i = 0; i < 10; i++) rd(8'h82 + 8'(i), cfg[i]);
      pw = o_powered;
      foreach (exp_settle[i]) wr(8'h80, 8'h57 + 8'(i << 4));
      wr(8'h80, 8'hC7);
      wr(8'h80, 8'h07);
      `CHK({o_powered, o_tone_synthesizer_en}, {pw, 1'b0})
      wr(8'h80, 8'hA0);
      `CHK({o_powered, o_pins_grounded}, 2'b01)
      conclude();
   end
   function automatic logic [7:0] i_real_b(input int i);
      return i[0] ? 8'h34 : 8'h12;
   endfunction : i_real_b
   function automatic logic [7:0] i_imag_b(input int i);
      return i[0] ? 8'hDC : 8'hFE;
   endfunction : i_imag_b
   // watchdog against a hung handshake
   initial begin
      #1000000;
      bad_count++;
      conclude();
   end
endmodule : test_impedance_sweep_sequencer
